// file: design/acs_pkg.sv
// Constants for the converter sequencer: offsets, fields, resets, counts.
// Assumes an APB master with 32-bit data and one word per register.
// Summary of operation
// - Input select chooses the pin channel or internal signal converted.
// - Reference select picks the full-scale reference source.
// - Format bit arranges the 12-bit result across the two bytes.
// - Interrupt needs global and converter enables both set.
// - Start bit low-high-low; the falling edge begins conversion.
// - Busy flag goes low when the conversion has finished.
// - Result bytes hold the value after completion.
// - Interrupt raised at completion when enabled and stack not full.
// - Result is 12 bits, full scale all ones, step is vref/4096.
// - Clearing power-on switches the converter off.
// - Comparator output debounced to a decision that raises an interrupt.
// - Decision can feed timer two capture input via source select.
// - Amplified sensing signal selectable as internal converter input.
// - Conversion is 4 sampling plus 12 converting clock cycles.
// - Divider codes 0 to 7 divide system clock by 1 to 128.
// - Codes 0-7 pins, 8-11 and 15 internal, 12-14 floating.
package acs_pkg;
	localparam logic [7:0] ADDR_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_CTRL1 = 8'h04;
	localparam logic [7:0] ADDR_RES_LO = 8'h08;
	localparam logic [7:0] ADDR_RES_HI = 8'h0C;
	localparam logic [7:0] ADDR_IRQ = 8'h10;
	localparam logic [7:0] ADDR_IR = 8'h14;
	// Control-first fields
	localparam int CTRL0_FMT_BIT = 4;
	localparam int CTRL0_PWR_BIT = 5;
	localparam int CTRL0_BUSY_BIT = 6;
	localparam int CTRL0_START_BIT = 7;
	// Control-second fields
	localparam int CTRL1_VREF_LSB = 6;
	// Interrupt register fields
	localparam int IRQ_GLOBAL_BIT = 0;
	localparam int IRQ_ADC_EN_BIT = 1;
	localparam int IRQ_ADC_FLAG_BIT = 2;
	localparam int IRQ_IR_EN_BIT = 3;
	localparam int IRQ_IR_FLAG_BIT = 4;
	// Infrared register fields
	localparam int IR_CAP_LSB = 4;
	localparam int IR_DECISION_BIT = 7;
	localparam logic [7:0] CTRL0_RESET = 8'h00;
	localparam logic [7:0] CTRL1_RESET = 8'h00;
	localparam logic [11:0] RESULT_RESET = 12'h000;
	localparam int RESULT_BITS = 12;
	localparam logic [11:0] RESULT_FULL_SCALE = 12'hFFF;
	localparam logic [3:0] SAMPLE_CYCLES = 4'h4;
	localparam logic [3:0] CONV_CYCLES = 4'hC;
	localparam logic [3:0] INPUT_FLOAT_LO = 4'hC;
	localparam logic [3:0] INPUT_FLOAT_HI = 4'hE;
	localparam logic [1:0] CAP_SRC_DECISION = 2'h1;
	typedef enum logic [2:0] {
		ACS_IDLE = 3'b001,
		ACS_SAMPLE = 3'b010,
		ACS_CONVERT = 3'b100
	} acs_state_t;
endpackage

// file: design/acs_ir_if.sv
// Link between the sequencer top and the comparator debouncer.
// Assumes both ends share pclk.
`timescale 1ns/1ps
`default_nettype none
interface acs_ir_if;
	logic raw;
	logic [2:0] deb_sel;
	logic decision;
	modport top (output raw, output deb_sel, input decision);
	modport deb (input raw, input deb_sel, output decision);
endinterface
`default_nettype wire

// file: design/acs_ir_debounce.sv
// Comparator debouncer for the infrared sensing decision.
// Assumes the raw comparator level is synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module acs_ir_debounce
(
	input wire logic pclk,
	input wire logic presetn,
	acs_ir_if.deb ir
);
	logic [6:0] cnt_reg;
	logic [6:0] limit;
	logic decision_reg;

	assign limit = 7'((8'h01 << ir.deb_sel) - 8'h01);
	assign ir.decision = decision_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_reg <= 7'h00;
		else if (ir.raw == decision_reg || ir.deb_sel == 3'h0)
			cnt_reg <= 7'h00;
		else if (cnt_reg != limit)
			cnt_reg <= cnt_reg + 7'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			decision_reg <= 1'b0;
		else if (ir.deb_sel == 3'h0 || cnt_reg == limit)
			decision_reg <= ir.raw;
	end
endmodule // acs_ir_debounce
`default_nettype wire

// file: design/acs_top.sv
// Converter sequencer: APB registers, clock divider, sample/convert
// sequence with successive approximation, result formatting, interrupts.
// Assumes the analog core compares its held input against sar_code.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module acs_top
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sar_cmp_in,
	input wire logic ir_cmp_in,
	input wire logic timer2_pin_in,
	input wire logic stack_full,
	output logic adc_power_on,
	output logic [3:0] adc_input_sel,
	output logic adc_input_float,
	output logic [1:0] adc_vref_sel,
	output logic adc_sample,
	output logic [11:0] sar_code,
	output logic adc_irq,
	output logic ir_irq,
	output logic ir_detect_decision,
	output logic timer2_capture_input
);
	logic [7:0] ctrl0_reg;
	logic [7:0] ctrl1_reg;
	logic [7:0] irq_reg;
	logic [7:0] ir_reg;
	logic [11:0] result_reg;
	logic [11:0] sar_reg;
	logic busy_reg;
	logic [6:0] div_cnt_reg;
	logic [3:0] step_reg;
	logic [3:0] bit_idx;
	logic start_prev_reg;
	logic decision_prev_reg;
	// Phase and sequencing state
	acs_pkg::acs_state_t state_reg;
	acs_pkg::acs_state_t state_next;
	logic wr_en;
	logic rd_hit;
	logic start_rise;
	logic start_fall;
	logic adc_tick;
	logic [6:0] div_limit;
	logic done;
	logic [11:0] trial;
	logic [7:0] res_lo;
	logic [7:0] res_hi;
	logic adc_flag_clr;
	logic ir_flag_clr;
	logic ir_rise;
	acs_ir_if ir_link();

	// Comparator filter
	acs_ir_debounce acs_ir_debounce_inst
	(
		.pclk(pclk),
		.presetn(presetn),
		.ir(ir_link)
	);

	// Zero wait state slave
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_hit = paddr == acs_pkg::ADDR_CTRL0 || paddr == acs_pkg::ADDR_CTRL1
		|| paddr == acs_pkg::ADDR_RES_LO || paddr == acs_pkg::ADDR_RES_HI
		|| paddr == acs_pkg::ADDR_IRQ || paddr == acs_pkg::ADDR_IR;
	assign pslverr = psel && penable && !rd_hit;

	// Control-first: input select, format, power, start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl0_reg <= acs_pkg::CTRL0_RESET;
		else if (wr_en && paddr == acs_pkg::ADDR_CTRL0)
			ctrl0_reg <= pwdata[7:0];
	end

	// Control-second: divider and reference
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl1_reg <= acs_pkg::CTRL1_RESET;
		else if (wr_en && paddr == acs_pkg::ADDR_CTRL1)
			ctrl1_reg <= pwdata[7:0];
	end

	// Infrared control: debounce select and capture source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ir_reg <= 8'h00;
		else if (wr_en && paddr == acs_pkg::ADDR_IR)
			ir_reg <= pwdata[7:0];
	end

	// Flags clear on a written zero
	assign adc_flag_clr = wr_en && paddr == acs_pkg::ADDR_IRQ && !pwdata[acs_pkg::IRQ_ADC_FLAG_BIT];
	assign ir_flag_clr = wr_en && paddr == acs_pkg::ADDR_IRQ && !pwdata[acs_pkg::IRQ_IR_FLAG_BIT];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_reg[acs_pkg::IRQ_GLOBAL_BIT] <= 1'b0;
			irq_reg[acs_pkg::IRQ_ADC_EN_BIT] <= 1'b0;
			irq_reg[acs_pkg::IRQ_IR_EN_BIT] <= 1'b0;
		end
		else if (wr_en && paddr == acs_pkg::ADDR_IRQ)
		begin
			irq_reg[acs_pkg::IRQ_GLOBAL_BIT] <= pwdata[acs_pkg::IRQ_GLOBAL_BIT];
			irq_reg[acs_pkg::IRQ_ADC_EN_BIT] <= pwdata[acs_pkg::IRQ_ADC_EN_BIT];
			irq_reg[acs_pkg::IRQ_IR_EN_BIT] <= pwdata[acs_pkg::IRQ_IR_EN_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_reg[acs_pkg::IRQ_ADC_FLAG_BIT] <= 1'b0;
		else if (done)
			irq_reg[acs_pkg::IRQ_ADC_FLAG_BIT] <= 1'b1;
		else if (adc_flag_clr)
			irq_reg[acs_pkg::IRQ_ADC_FLAG_BIT] <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_reg[acs_pkg::IRQ_IR_FLAG_BIT] <= 1'b0;
		else if (ir_rise)
			irq_reg[acs_pkg::IRQ_IR_FLAG_BIT] <= 1'b1;
		else if (ir_flag_clr)
			irq_reg[acs_pkg::IRQ_IR_FLAG_BIT] <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_reg[7:5] <= 3'h0;
		end
		else
		begin
			// Unused upper bits
			irq_reg[7:5] <= 3'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			start_prev_reg <= 1'b0;
		else
			start_prev_reg <= ctrl0_reg[acs_pkg::CTRL0_START_BIT];
	end

	assign start_rise = ctrl0_reg[acs_pkg::CTRL0_START_BIT] && !start_prev_reg;
	assign start_fall = !ctrl0_reg[acs_pkg::CTRL0_START_BIT] && start_prev_reg;

	// Divide by two to the code
	assign div_limit = 7'((8'h01 << ctrl1_reg[2:0]) - 8'h01);
	assign adc_tick = div_cnt_reg == div_limit;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt_reg <= 7'h00;
		else if (state_reg == acs_pkg::ACS_IDLE || adc_tick || start_fall)
			div_cnt_reg <= 7'h00;
		else
			div_cnt_reg <= div_cnt_reg + 7'h01;
	end

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			acs_pkg::ACS_IDLE:
				if (start_fall)
					state_next = acs_pkg::ACS_SAMPLE;
			acs_pkg::ACS_SAMPLE:
				if (adc_tick && step_reg == acs_pkg::SAMPLE_CYCLES - 4'h1)
					state_next = acs_pkg::ACS_CONVERT;
			acs_pkg::ACS_CONVERT:
				if (adc_tick && step_reg == acs_pkg::CONV_CYCLES - 4'h1)
					state_next = acs_pkg::ACS_IDLE;
			default:
				state_next = acs_pkg::ACS_IDLE;
		endcase
		if (!ctrl0_reg[acs_pkg::CTRL0_PWR_BIT])
			state_next = acs_pkg::ACS_IDLE;
		else if (start_rise)
			state_next = acs_pkg::ACS_IDLE;
		else if (start_fall)
			state_next = acs_pkg::ACS_SAMPLE;
	end

	// Sequencer state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= acs_pkg::ACS_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			step_reg <= 4'h0;
		else if (state_next != state_reg || start_fall)
			step_reg <= 4'h0;
		else if (adc_tick)
			step_reg <= step_reg + 4'h1;
	end

	assign done = state_reg == acs_pkg::ACS_CONVERT && state_next == acs_pkg::ACS_IDLE
		&& ctrl0_reg[acs_pkg::CTRL0_PWR_BIT] && !start_rise && !start_fall;

	assign bit_idx = acs_pkg::CONV_CYCLES - 4'h1 - step_reg;
	assign trial = sar_reg | (12'h001 << bit_idx);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sar_reg <= acs_pkg::RESULT_RESET;
		else if (state_reg != acs_pkg::ACS_CONVERT)
			sar_reg <= acs_pkg::RESULT_RESET;
		else if (adc_tick && sar_cmp_in)
			sar_reg <= trial;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			result_reg <= acs_pkg::RESULT_RESET;
		else if (done)
			result_reg <= sar_cmp_in ? trial : sar_reg;
	end

	// Busy from start edge to completion
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			busy_reg <= 1'b0;
		else
			busy_reg <= state_next != acs_pkg::ACS_IDLE;
	end

	always_comb
	begin
		if (ctrl0_reg[acs_pkg::CTRL0_FMT_BIT])
		begin
			res_hi = {4'h0, result_reg[11:8]};
			res_lo = result_reg[7:0];
		end
		else
		begin
			res_hi = result_reg[11:4];
			res_lo = {result_reg[3:0], 4'h0};
		end
	end

	always_comb
	begin
		prdata = 32'h0000_0000;
		if (paddr == acs_pkg::ADDR_CTRL0)
			prdata[7:0] = {ctrl0_reg[7], busy_reg, ctrl0_reg[5:0]};
		else if (paddr == acs_pkg::ADDR_CTRL1)
			prdata[7:0] = {ctrl1_reg[7:6], 3'h0, ctrl1_reg[2:0]};
		else if (paddr == acs_pkg::ADDR_RES_LO)
			prdata[7:0] = res_lo;
		else if (paddr == acs_pkg::ADDR_RES_HI)
			prdata[7:0] = res_hi;
		else if (paddr == acs_pkg::ADDR_IRQ)
			prdata[7:0] = {3'h0, irq_reg[4:0]};
		else if (paddr == acs_pkg::ADDR_IR)
			prdata[7:0] = {ir_detect_decision, 1'b0, ir_reg[5:4], 1'b0, ir_reg[2:0]};
	end

	assign adc_input_sel = ctrl0_reg[3:0];
	assign adc_input_float = adc_input_sel >= acs_pkg::INPUT_FLOAT_LO
		&& adc_input_sel <= acs_pkg::INPUT_FLOAT_HI;
	assign adc_vref_sel = ctrl1_reg[acs_pkg::CTRL1_VREF_LSB +: 2];
	assign adc_power_on = ctrl0_reg[acs_pkg::CTRL0_PWR_BIT];
	assign adc_sample = state_reg == acs_pkg::ACS_SAMPLE;
	assign sar_code = state_reg == acs_pkg::ACS_CONVERT ? trial : sar_reg;

	// Not raised while stack is full
	assign adc_irq = irq_reg[acs_pkg::IRQ_ADC_FLAG_BIT] && irq_reg[acs_pkg::IRQ_ADC_EN_BIT]
		&& irq_reg[acs_pkg::IRQ_GLOBAL_BIT] && !stack_full;

	assign ir_link.raw = ir_cmp_in;
	assign ir_link.deb_sel = ir_reg[2:0];
	assign ir_detect_decision = ir_link.decision;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			decision_prev_reg <= 1'b0;
		else
			decision_prev_reg <= ir_link.decision;
	end

	assign ir_rise = ir_link.decision && !decision_prev_reg;
	assign ir_irq = irq_reg[acs_pkg::IRQ_IR_FLAG_BIT] && irq_reg[acs_pkg::IRQ_IR_EN_BIT]
		&& irq_reg[acs_pkg::IRQ_GLOBAL_BIT] && !stack_full;

	assign timer2_capture_input = ir_reg[acs_pkg::IR_CAP_LSB +: 2] == acs_pkg::CAP_SRC_DECISION
		? ir_link.decision : timer2_pin_in;

endmodule // acs_top
`default_nettype wire

// file: testbench/acs_top_assertions.sv
// Port checker for the converter sequencer top.
// Assumes bind onto acs_top; one pclk domain.
`timescale 1ns/1ps
`default_nettype none
module acs_top_assertions
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pslverr,
	input wire logic timer2_pin_in,
	input wire logic stack_full,
	input wire logic adc_power_on,
	input wire logic [3:0] adc_input_sel,
	input wire logic adc_input_float,
	input wire logic adc_sample,
	input wire logic [11:0] sar_code,
	input wire logic adc_irq,
	input wire logic ir_irq,
	input wire logic ir_detect_decision,
	input wire logic timer2_capture_input
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence samp_start; $rose(adc_sample); endsequence
	sequence samp_end; $fell(adc_sample) && adc_power_on; endsequence
	AST_PSLVERR: assert property (psel && penable |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0))
		else $error("pslverr wrong");
	AST_FLOAT: assert property (adc_input_float == (adc_input_sel >= 4'hC && adc_input_sel <= 4'hE))
		else $error("float wrong");
	AST_STACK: assert property (stack_full |-> !adc_irq && !ir_irq)
		else $error("irq while stack full");
	AST_POWER: assert property (!adc_power_on |-> !adc_sample)
		else $error("sampling while off");
	AST_SAMP_MIN: assert property (samp_start |-> adc_sample [*4])
		else $error("sampling too short");
	AST_SAMP_MAX: assert property (samp_start |-> ##[1:512] !adc_sample)
		else $error("sampling too long");
	AST_SAR_MSB: assert property (samp_end |-> sar_code == 12'h800)
		else $error("first trial wrong");
	AST_CAPMUX: assert property (timer2_capture_input != timer2_pin_in |-> timer2_capture_input == ir_detect_decision)
		else $error("capture mux wrong");
endmodule // acs_top_assertions
bind acs_top acs_top_assertions acs_top_assertions_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pslverr(pslverr), .timer2_pin_in(timer2_pin_in), .stack_full(stack_full),
	.adc_power_on(adc_power_on), .adc_input_sel(adc_input_sel), .adc_input_float(adc_input_float),
	.adc_sample(adc_sample), .sar_code(sar_code), .adc_irq(adc_irq), .ir_irq(ir_irq),
	.ir_detect_decision(ir_detect_decision), .timer2_capture_input(timer2_capture_input));
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the converter sequencer over APB.
// Assumes an ideal comparator: input level held in tgt.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, sar_cmp_in, ir_cmp_in = 1'b0, timer2_pin_in = 1'b0, stack_full = 1'b0;
	logic adc_power_on, adc_input_float, adc_sample, adc_irq, ir_irq, ir_detect_decision, timer2_capture_input;
	logic [3:0] adc_input_sel;
	logic [1:0] adc_vref_sel;
	logic [11:0] sar_code, tgt = 12'h000;
	int error_cnt = 0, num_checks = 0, samp_cnt = 0;
	assign sar_cmp_in = (tgt >= sar_code);
	always #12.5 pclk = ~pclk;
	always @(posedge pclk)
		if (adc_sample === 1'b1)
			samp_cnt <= samp_cnt + 1;
	acs_top acs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sar_cmp_in(sar_cmp_in), .ir_cmp_in(ir_cmp_in), .timer2_pin_in(timer2_pin_in), .stack_full(stack_full),
		.adc_power_on(adc_power_on), .adc_input_sel(adc_input_sel), .adc_input_float(adc_input_float),
		.adc_vref_sel(adc_vref_sel), .adc_sample(adc_sample), .sar_code(sar_code), .adc_irq(adc_irq),
		.ir_irq(ir_irq), .ir_detect_decision(ir_detect_decision), .timer2_capture_input(timer2_capture_input));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Entered just after an edge; leaves one idle edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge pclk);
			n++;
		end
		r = prdata;
		chk("pready", 32'(pready), 32'h1);
		chk("pslverr", 32'(pslverr), 32'(a > 8'h14));
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [31:0] c0(input logic s, input logic f, input logic p);
		return {24'h0, s, 1'b0, p, f, 4'h0};
	endfunction
	task automatic conv(input logic [2:0] dv, input logic [11:0] v, input logic fm, input logic [1:0] en,
		input int rs);
		int s0, n;
		logic [15:0] e;
		e = fm ? {4'h0, v} : {v, 4'h0};
		tgt <= v;
		apb(1'b1, acs_pkg::ADDR_IRQ, {30'h0, en});
		apb(1'b1, acs_pkg::ADDR_CTRL1, {24'h0, v[1:0], 3'h0, dv});
		chk("vref", 32'(adc_vref_sel), 32'(v[1:0]));
		s0 = samp_cnt;
		for (int k = 0; k <= rs; k++)
		begin
			apb(1'b1, acs_pkg::ADDR_CTRL0, c0(1'b1, fm, 1'b1));
			apb(1'b1, acs_pkg::ADDR_CTRL0, c0(1'b0, fm, 1'b1));
			apb(1'b0, acs_pkg::ADDR_CTRL0, 32'h0);
			chk("busy", 32'(r[6]), 32'h1);
			n = 0;
			while (adc_sample === 1'b1 && n < 2000)
			begin
				@(posedge pclk);
				n++;
			end
		end
		n = 0;
		do
		begin
			apb(1'b0, acs_pkg::ADDR_CTRL0, 32'h0);
			n++;
		end
		while (r[6] !== 1'b0 && n < 500);
		chk("busy end", 32'(r[6]), 32'h0);
		chk("samp len", samp_cnt - s0, (4 * (rs + 1)) << dv);
		apb(1'b0, acs_pkg::ADDR_IRQ, 32'h0);
		chk("flag", 32'(r[2]), 32'h1);
		chk("adc irq", 32'(adc_irq), 32'(en == 2'h3 && !stack_full));
		apb(1'b0, acs_pkg::ADDR_RES_LO, 32'h0);
		chk("res lo", r, 32'(e[7:0]));
		apb(1'b0, acs_pkg::ADDR_RES_HI, 32'h0);
		chk("res hi", r, 32'(e[15:8]));
		apb(1'b1, acs_pkg::ADDR_IRQ, {30'h0, en});
		chk("irq clr", 32'(adc_irq), 32'h0);
		$display("test conv done");
	endtask
	initial
	begin
		#1000000;
		error_cnt++;
		finish_test;
	end
	initial
	begin
		void'($urandom(49978));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk("reset", r, 32'h0);
		end
		$display("test reset done");
		for (int i = 0; i < 16; i++)
		begin
			apb(1'b1, acs_pkg::ADDR_CTRL0, 32'(i));
			chk("sel", 32'(adc_input_sel), 32'(i));
			chk("float", 32'(adc_input_float), 32'(i >= 12 && i <= 14));
		end
		$display("test select done");
		conv(3'h0, 12'hFFF, 1'b0, 2'h3, 0);
		conv(3'h2, 12'h000, 1'b1, 2'h3, 0);
		for (int i = 0; i < 6; i++)
		begin
			stack_full <= 1'($urandom);
			conv(3'($urandom_range(2, 0)), 12'($urandom), 1'($urandom), 2'($urandom), i % 3 == 1);
		end
		apb(1'b1, acs_pkg::ADDR_CTRL0, c0(1'b1, 1'b0, 1'b1));
		apb(1'b1, acs_pkg::ADDR_CTRL0, c0(1'b0, 1'b0, 1'b1));
		repeat (8) @(posedge pclk);
		apb(1'b1, acs_pkg::ADDR_CTRL0, 32'h0);
		chk("power", 32'(adc_power_on), 32'h0);
		repeat (100) @(posedge pclk);
		apb(1'b0, acs_pkg::ADDR_IRQ, 32'h0);
		chk("no flag", 32'(r[2]), 32'h0);
		$display("test power done");
		stack_full <= 1'b0;
		apb(1'b1, acs_pkg::ADDR_IR, 32'h12);
		apb(1'b1, acs_pkg::ADDR_IRQ, 32'h9);
		ir_cmp_in <= 1'b1;
		repeat (12) @(posedge pclk);
		chk("decision", 32'(ir_detect_decision), 32'h1);
		chk("ir irq", 32'(ir_irq), 32'h1);
		chk("cap dec", 32'(timer2_capture_input), 32'h1);
		apb(1'b1, acs_pkg::ADDR_IR, 32'h02);
		chk("cap pin", 32'(timer2_capture_input), 32'h0);
		stack_full <= 1'b1;
		@(posedge pclk);
		@(posedge pclk);
		chk("ir mask", 32'(ir_irq), 32'h0);
		$display("test ir done");
		finish_test;
	end
endmodule // tb_top
`default_nettype wire
